// ---- hsd_map.svh ----
`ifndef HSD_MAP_SVH
`define HSD_MAP_SVH

// register byte offsets
`define HSD_OFF_CONFIG     8'h00
`define HSD_OFF_DATA       8'h04
`define HSD_OFF_TEST       8'h08
`define HSD_OFF_OL_STATUS  8'h0C
`define HSD_OFF_IRQ_EN     8'h10
`define HSD_OFF_IRQ_FLAGS  8'h14
`define HSD_OFF_ROUTE      8'h18

// field positions
`define HSD_CFG_EN_LSB     0
`define HSD_CFG_OLE_LSB    2
`define HSD_CFG_OCME_LSB   4
`define HSD_IE_OCIE_BIT    7
`define HSD_ROUTE_W        2

// reset values
`define HSD_RST_CONFIG     6'h00
`define HSD_RST_DATA       2'h0
`define HSD_RST_TEST       8'h00
`define HSD_RST_IRQ_EN     1'h0
`define HSD_RST_ROUTE      4'h0

// axi responses
`define HSD_RESP_OKAY      2'h0
`define HSD_RESP_SLVERR    2'h2

// timing: masking window after switch-on, rounded up to cycles
`define HSD_CLK_MHZ        200
`define HSD_OCM_TIME_NS    1000
`define HSD_OCM_CYCLES     ((`HSD_OCM_TIME_NS * `HSD_CLK_MHZ + 999) / 1000)

`endif

// ---- hsd_pkg.sv ----
`default_nettype none

package hsd_pkg;

    localparam int HSD_NCH = 2;

    // control source of one driver channel
    typedef enum logic [1:0] {
        HSD_SRC_REG   = 2'h0,
        HSD_SRC_TIMER = 2'h1,
        HSD_SRC_PWM   = 2'h2,
        HSD_SRC_REG2  = 2'h3
    } hsd_src_t;

    // comparator levels coming from the analog stages
    typedef struct packed {
        logic [1:0] oc_cmp;
        logic [1:0] ol_cmp;
    } hsd_ana_in_t;

    // controls going to the analog stages
    typedef struct packed {
        logic [1:0] drv_on;
        logic [1:0] bias_en;
        logic [1:0] ol_det_on;
        logic [7:0] test_bits;
    } hsd_ana_out_t;

    // routed switching sources
    typedef struct packed {
        logic [1:0] timer;
        logic [1:0] pwm;
    } hsd_route_in_t;

endpackage

`default_nettype wire

// ---- hsd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for asynchronous comparator levels
module hsd_sync #(
    parameter int W = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second stage
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_ff <= '0;
            q_ff    <= '0;
        end
        else
        begin
            meta_ff <= d_async;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule // hsd_sync

`default_nettype wire

// ---- hsd_chan.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hsd_map.svh"

// one driver channel: switching, over-current latch, mask window, open load
module hsd_chan (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic enable,
    input  wire logic src_on,
    input  wire logic mask_en,
    input  wire logic ol_det_en,
    input  wire logic oc_sync,
    input  wire logic ol_sync,
    input  wire logic flag_clr,
    output logic      drv_on,
    output logic      flag,
    output logic      ol_active,
    output logic      ol_status
);
    localparam int CW = $clog2(`HSD_OCM_CYCLES + 1);
    localparam logic [CW-1:0] MASK_LOAD = CW'(`HSD_OCM_CYCLES);

    logic          drv_ff;
    logic          flag_ff;
    logic          ol_ff;
    logic [CW-1:0] mask_cnt_ff;
    logic          want_on;
    logic          switch_on;
    logic          masking;
    logic          oc_event;
    logic          ol_window;

    // driver follows its source unless latched off
    assign want_on   = enable & src_on & ~flag_ff;
    assign switch_on = want_on & ~drv_ff;
    assign masking   = mask_en & (mask_cnt_ff != '0);
    assign oc_event  = oc_sync & drv_ff & ~masking;
    assign ol_window = enable & ol_det_en & ~src_on;

    // state of the channel; a new event beats a clear in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drv_ff      <= 1'b0;
            flag_ff     <= 1'b0;
            ol_ff       <= 1'b0;
            mask_cnt_ff <= '0;
        end
        else
        begin
            drv_ff  <= want_on & ~oc_event;
            flag_ff <= oc_event | (flag_ff & ~flag_clr);
            ol_ff   <= ol_window & ol_sync;
            if (switch_on)
                mask_cnt_ff <= MASK_LOAD;
            else if (mask_cnt_ff != '0)
                mask_cnt_ff <= mask_cnt_ff - CW'(1);
        end
    end

    assign drv_on    = drv_ff;
    assign flag      = flag_ff;
    assign ol_active = ol_window;
    assign ol_status = ol_ff;
endmodule // hsd_chan

`default_nettype wire

// ---- hsd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "hsd_map.svh"

// Notes on behaviour
// - two drivers, register or routed source
// - driver follows its selected control source
// - test register writable only in special mode
// - test bits reach analog stages only
// - open-load status read only, per channel
// - open-load detect only enabled and undriven
// - open load when pin stays high
// - bit 7 enables over-current interrupt
// - over-current sets channel flag
// - write one clears flag, zero ignored
// - set flag forces driver off
// - cleared flag returns control to source
// - mask enable hides over-current after switch-on
// - mask enable writable only while disabled
// - interrupt only in run mode, flags kept
// - single interrupt from over-current only
// - driver enable bits bias drivers
// - open-load enable bits start detection
module hsd_top (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  special_mode,
    input  wire logic                  run_mode,
    input  wire hsd_pkg::hsd_route_in_t route_in,
    input  wire hsd_pkg::hsd_ana_in_t   ana_in,
    output hsd_pkg::hsd_ana_out_t       ana_out,
    output logic                       module_interrupt
);
    import hsd_pkg::*;

    // register address match, used by both read and write decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
        reg_hit = (a[7:2] == off[7:2]);
    endfunction

    // software-visible state
    logic [1:0]  driver_enable_bit_ff;
    logic [1:0]  open_load_detect_en_ff;
    logic [1:0]  overcurrent_mask_en_ff;
    logic [1:0]  driver_data_bit_ff;
    logic [7:0]  factory_test_reg_ff;
    logic        overcurrent_int_en_ff;
    hsd_src_t    route_sel_ff [HSD_NCH];
    localparam logic [3:0] RST_ROUTE = `HSD_RST_ROUTE;

    // bus slave state
    logic        awready_ff;
    logic        wready_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        irq_ff;
    hsd_ana_out_t ana_ff;

    // channel wires
    logic [1:0]  src_on;
    logic [1:0]  drv_on;
    logic [1:0]  oc_flag;
    logic [1:0]  ol_active;
    logic [1:0]  open_load_bit;
    logic [1:0]  flag_clr;
    logic [1:0]  data_view;
    logic [3:0]  cmp_sync;

    // write decode
    logic        aw_take;
    logic        w_take;
    logic        do_write;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic        wlane0;
    logic        wlane1;
    logic        wr_cfg;
    logic        wr_data;
    logic        wr_test;
    logic        wr_ie;
    logic        wr_if;
    logic        wr_route;
    logic        wr_ro;
    logic        w_mapped;
    logic [1:0]  nxt_mask_en;

    // read decode
    logic        ar_take;
    logic [7:0]  ra;
    logic [31:0] nxt_rdata;
    logic        r_mapped;
    logic        nxt_irq;

    // comparator levels cross into the bus clock first
    hsd_sync #(.W(4)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d_async ({ana_in.oc_cmp, ana_in.ol_cmp}),
        .q       (cmp_sync)
    );

    // per-channel source selection and channel logic
    genvar gi;
    generate
        for (gi = 0; gi < HSD_NCH; gi++)
        begin : g_ch
            assign src_on[gi] =
                (route_sel_ff[gi] == HSD_SRC_TIMER) ? route_in.timer[gi] :
                (route_sel_ff[gi] == HSD_SRC_PWM)   ? route_in.pwm[gi]   :
                driver_data_bit_ff[gi];
            assign data_view[gi] = driver_enable_bit_ff[gi] ? src_on[gi]
                                                            : driver_data_bit_ff[gi];
            // a mask bit only takes a write while its driver is disabled
            assign nxt_mask_en[gi] = (wr_cfg && wlane0 && !driver_enable_bit_ff[gi])
                ? wd[`HSD_CFG_OCME_LSB + gi] : overcurrent_mask_en_ff[gi];
            assign flag_clr[gi] = wr_if & wlane0 & wd[gi];

            hsd_chan u_chan (
                .aclk      (aclk),
                .aresetn   (aresetn),
                .enable    (driver_enable_bit_ff[gi]),
                .src_on    (src_on[gi]),
                .mask_en   (overcurrent_mask_en_ff[gi]),
                .ol_det_en (open_load_detect_en_ff[gi]),
                .oc_sync   (cmp_sync[2 + gi]),
                .ol_sync   (cmp_sync[gi]),
                .flag_clr  (flag_clr[gi]),
                .drv_on    (drv_on[gi]),
                .flag      (oc_flag[gi]),
                .ol_active (ol_active[gi]),
                .ol_status (open_load_bit[gi])
            );
        end
    endgenerate

    // write channel: address and data taken in either order
    assign aw_take  = s_axi_awvalid & awready_ff;
    assign w_take   = s_axi_wvalid & wready_ff;
    assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign wa       = waddr_ff;
    assign wd       = wdata_ff;
    assign wlane0   = wstrb_ff[0];
    assign wlane1   = wstrb_ff[1];
    assign wr_cfg   = do_write & reg_hit(wa, `HSD_OFF_CONFIG);
    assign wr_data  = do_write & reg_hit(wa, `HSD_OFF_DATA);
    assign wr_test  = do_write & reg_hit(wa, `HSD_OFF_TEST);
    assign wr_ie    = do_write & reg_hit(wa, `HSD_OFF_IRQ_EN);
    assign wr_if    = do_write & reg_hit(wa, `HSD_OFF_IRQ_FLAGS);
    assign wr_route = do_write & reg_hit(wa, `HSD_OFF_ROUTE);
    assign wr_ro    = reg_hit(wa, `HSD_OFF_OL_STATUS);
    assign w_mapped = reg_hit(wa, `HSD_OFF_CONFIG) | reg_hit(wa, `HSD_OFF_DATA)
                    | reg_hit(wa, `HSD_OFF_TEST) | reg_hit(wa, `HSD_OFF_IRQ_EN)
                    | reg_hit(wa, `HSD_OFF_IRQ_FLAGS) | reg_hit(wa, `HSD_OFF_ROUTE)
                    | wr_ro;

    // read channel decode
    assign ar_take  = s_axi_arvalid & arready_ff;
    assign ra       = s_axi_araddr;
    assign r_mapped = reg_hit(ra, `HSD_OFF_CONFIG) | reg_hit(ra, `HSD_OFF_DATA)
                    | reg_hit(ra, `HSD_OFF_TEST) | reg_hit(ra, `HSD_OFF_OL_STATUS)
                    | reg_hit(ra, `HSD_OFF_IRQ_EN) | reg_hit(ra, `HSD_OFF_IRQ_FLAGS)
                    | reg_hit(ra, `HSD_OFF_ROUTE);
    assign nxt_rdata =
        reg_hit(ra, `HSD_OFF_CONFIG)    ? {26'h0, overcurrent_mask_en_ff,
                                           open_load_detect_en_ff, driver_enable_bit_ff} :
        reg_hit(ra, `HSD_OFF_DATA)      ? {30'h0, data_view} :
        reg_hit(ra, `HSD_OFF_TEST)      ? {24'h0, factory_test_reg_ff} :
        reg_hit(ra, `HSD_OFF_OL_STATUS) ? {30'h0, open_load_bit} :
        reg_hit(ra, `HSD_OFF_IRQ_EN)    ? {24'h0, overcurrent_int_en_ff, 7'h00} :
        reg_hit(ra, `HSD_OFF_IRQ_FLAGS) ? {30'h0, oc_flag} :
        reg_hit(ra, `HSD_OFF_ROUTE)     ? {28'h0, route_sel_ff[1], route_sel_ff[0]} :
        32'h0000_0000;

    // one interrupt line: any flag, enabled, and only while running
    assign nxt_irq = overcurrent_int_en_ff & (|oc_flag) & run_mode;

    // write address and data capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            waddr_ff   <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
        end
        else
        begin
            awready_ff <= ~aw_held_ff & ~aw_take & ~do_write;
            wready_ff  <= ~w_held_ff & ~w_take & ~do_write;
            if (aw_take)
            begin
                aw_held_ff <= 1'b1;
                waddr_ff   <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_ff <= 1'b0;
            if (w_take)
            begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
                wstrb_ff  <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_ff <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `HSD_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= w_mapped ? `HSD_RESP_OKAY : `HSD_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // configuration, data and routing registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {overcurrent_mask_en_ff, open_load_detect_en_ff, driver_enable_bit_ff}
                <= `HSD_RST_CONFIG;
            driver_data_bit_ff <= `HSD_RST_DATA;
            route_sel_ff[0] <= hsd_src_t'(RST_ROUTE[1:0]);
            route_sel_ff[1] <= hsd_src_t'(RST_ROUTE[3:2]);
        end
        else
        begin
            overcurrent_mask_en_ff <= nxt_mask_en;
            if (wr_cfg && wlane0)
            begin
                driver_enable_bit_ff   <= wd[`HSD_CFG_EN_LSB +: 2];
                open_load_detect_en_ff <= wd[`HSD_CFG_OLE_LSB +: 2];
            end
            // data bits clear while the device is stopped
            if (!run_mode)
                driver_data_bit_ff <= `HSD_RST_DATA;
            else if (wr_data && wlane0)
                driver_data_bit_ff <= wd[1:0];
            if (wr_route && wlane0)
            begin
                route_sel_ff[0] <= hsd_src_t'(wd[1:0]);
                route_sel_ff[1] <= hsd_src_t'(wd[3:2]);
            end
        end
    end

    // test and interrupt enable registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            factory_test_reg_ff   <= `HSD_RST_TEST;
            overcurrent_int_en_ff <= `HSD_RST_IRQ_EN;
        end
        else
        begin
            if (wr_test && wlane0 && special_mode)
                factory_test_reg_ff <= wd[7:0];
            if (wr_ie && wlane0)
                overcurrent_int_en_ff <= wd[`HSD_IE_OCIE_BIT];
        end
    end

    // read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `HSD_RESP_OKAY;
        end
        else
        begin
            arready_ff <= ~rvalid_ff & ~ar_take;
            if (ar_take)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= nxt_rdata;
                rresp_ff  <= r_mapped ? `HSD_RESP_OKAY : `HSD_RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_ff <= 1'b0;
        end
    end

    // registered controls toward the analog stages and interrupt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ana_ff <= '0;
            irq_ff <= 1'b0;
        end
        else
        begin
            ana_ff.drv_on    <= drv_on;
            ana_ff.bias_en   <= driver_enable_bit_ff;
            ana_ff.ol_det_on <= ol_active;
            ana_ff.test_bits <= factory_test_reg_ff;
            irq_ff           <= nxt_irq;
        end
    end

    assign s_axi_awready    = awready_ff;
    assign s_axi_wready     = wready_ff;
    assign s_axi_bvalid     = bvalid_ff;
    assign s_axi_bresp      = bresp_ff;
    assign s_axi_arready    = arready_ff;
    assign s_axi_rvalid     = rvalid_ff;
    assign s_axi_rdata      = rdata_ff;
    assign s_axi_rresp      = rresp_ff;
    assign ana_out          = ana_ff;
    assign module_interrupt = irq_ff;
endmodule // hsd_top

`default_nettype wire

// ---- hsd_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none

// port-level relations of bus answers and protection outputs
module hsd_top_checker (
    input wire logic                   aclk,
    input wire logic                   aresetn,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [1:0]             s_axi_rresp,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic                   special_mode,
    input wire logic                   run_mode,
    input wire hsd_pkg::hsd_ana_out_t  ana_out,
    input wire logic                   module_interrupt
);
    import hsd_pkg::*;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // write response two edges after both halves are taken
    property p_btime;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_btime: assert property (p_btime) else $error("write answer late");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");

    property p_rtime;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rtime: assert property (p_rtime) else $error("read answer late");

    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");

    property p_arblk;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_arblk: assert property (p_arblk) else $error("address taken while answering");

    property p_stop_irq;
        !run_mode |=> !module_interrupt;
    endproperty
    a_stop_irq: assert property (p_stop_irq) else $error("interrupt in stop");

    property p_irq_run;
        $rose(module_interrupt) |-> $past(run_mode);
    endproperty
    a_irq_run: assert property (p_irq_run) else $error("interrupt from stop");

    // test bits frozen once special mode has been off a while
    property p_test_hold;
        !special_mode [*4] |=> $stable(ana_out.test_bits);
    endproperty
    a_test_hold: assert property (p_test_hold) else $error("test bits moved");

    property p_ol_bias;
        (ana_out.ol_det_on & ~ana_out.bias_en) == 2'h0;
    endproperty
    a_ol_bias: assert property (p_ol_bias) else $error("detect on unbiased driver");
endmodule // hsd_top_checker

bind hsd_top hsd_top_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .special_mode, .run_mode, .ana_out, .module_interrupt);

`default_nettype wire

// ---- hsd_ana_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// analog stages: comparators seen from the driven pins and their loads
module hsd_ana_model (
    input wire hsd_pkg::hsd_ana_out_t  ana_out,
    input wire logic [1:0]             short_ld,
    input wire logic [1:0]             open_ld,
    output hsd_pkg::hsd_ana_in_t       ana_in
);
    import hsd_pkg::*;

    // shorted load draws excess current only while driven
    assign ana_in.oc_cmp = ana_out.drv_on & short_ld;
    // pin sits high when driven, or when detect current meets an open load
    assign ana_in.ol_cmp = (ana_out.ol_det_on & open_ld) | ana_out.drv_on;
endmodule // hsd_ana_model

`default_nettype wire

// ---- hsd_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module hsd_top_test;
    import hsd_pkg::*;

    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, special_mode, run_mode, module_interrupt;
    logic [7:0]    s_axi_awaddr, s_axi_araddr, rv;
    logic [31:0]   s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp, rd_r, wr_b, short_ld, open_ld, dat, sel;
    hsd_route_in_t route_in;
    hsd_ana_in_t   ana_in;
    hsd_ana_out_t  ana_out;
    int            err_count, tests_run;

    hsd_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .special_mode,
        .run_mode, .route_in, .ana_in, .ana_out, .module_interrupt);
    hsd_ana_model u_ana (.ana_out, .short_ld, .open_ld, .ana_in);

    always #2.5 aclk = ~aclk;

    // expected drive per channel from the selected source
    function automatic logic [1:0] exp_drv(input logic [1:0] s, d, t, p);
        exp_drv = (s == HSD_SRC_TIMER) ? t : (s == HSD_SRC_PWM) ? p : d;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            err_count++;
        end
    endtask

    // one write, both halves offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (!aw && s_axi_awready)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // answer is left waiting one cycle before the master takes it
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        wr_b = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        // read answer must hold while the master is not yet ready
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(rd_d, e);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // cuts a hang short
    initial
    begin
        repeat (20000) @(posedge aclk);
        err_count++;
        results();
    end

    initial
    begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
        {s_axi_arvalid, s_axi_rready, special_mode, run_mode} = 4'h1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {short_ld, open_ld, route_in} = 8'h00;
        err_count = 0;
        tests_run = 0;
        void'($urandom(55));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        // reset values, then an unmapped place
        for (int i = 0; i < 7; i++)
            rc(8'(i * 4), 32'h0);
        rd(8'h1C);
        chk(rd_d, 32'h0);
        chk(rd_r, 2'h2);
        wr(8'h1C, 32'h0);
        chk(wr_b, 2'h2);
        // test register written only in special mode
        wr(8'h08, 32'hA5);
        rc(8'h08, 32'h0);
        rv = 8'($urandom);
        special_mode <= 1'b1;
        wr(8'h08, rv);
        rc(8'h08, rv);
        chk(ana_out.test_bits, rv);
        special_mode <= 1'b0;
        wr(8'h08, 32'h0);
        rc(8'h08, rv);
        // every control source on both channels
        wr(8'h00, 32'h03);
        chk(ana_out.bias_en, 2'h3);
        for (int s = 0; s < 8; s++)
        begin
            sel = 2'(s);
            dat = 2'($urandom);
            wr(8'h18, {sel, sel});
            wr(8'h04, dat);
            route_in <= 4'($urandom);
            repeat (5) @(posedge aclk);
            chk(ana_out.drv_on, exp_drv(sel, dat, route_in.timer, route_in.pwm));
            rc(8'h04, exp_drv(sel, dat, route_in.timer, route_in.pwm));
        end
        // over-current latch, shutdown, interrupt and clear
        wr(8'h18, 32'h0);
        wr(8'h10, 32'h80);
        short_ld <= 2'h1;
        wr(8'h04, 32'h3);
        repeat (10) @(posedge aclk);
        chk(ana_out.drv_on, 2'h2);
        rc(8'h14, 32'h1);
        chk(module_interrupt, 1'b1);
        wr(8'h10, 32'h0);
        repeat (3) @(posedge aclk);
        chk(module_interrupt, 1'b0);
        wr(8'h10, 32'h80);
        run_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(module_interrupt, 1'b0);
        rc(8'h14, 32'h1);
        run_mode <= 1'b1;
        wr(8'h14, 32'h0);
        rc(8'h14, 32'h1);
        short_ld <= 2'h0;
        wr(8'h14, 32'h1);
        rc(8'h14, 32'h0);
        wr(8'h04, 32'h3);
        repeat (5) @(posedge aclk);
        chk(ana_out.drv_on, 2'h3);
        // mask window after switch-on, mask bit locked while enabled
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h00);
        wr(8'h00, 32'h11);
        wr(8'h00, 32'h01);
        rc(8'h00, 32'h11);
        short_ld <= 2'h1;
        wr(8'h04, 32'h1);
        repeat (100) @(posedge aclk);
        chk(ana_out.drv_on, 2'h1);
        rc(8'h14, 32'h0);
        repeat (150) @(posedge aclk);
        rc(8'h14, 32'h1);
        short_ld <= 2'h0;
        wr(8'h14, 32'h1);
        // open load only on enabled, undriven channels
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0F);
        open_ld <= 2'h3;
        repeat (6) @(posedge aclk);
        rc(8'h0C, 32'h3);
        chk(ana_out.ol_det_on, 2'h3);
        wr(8'h0C, 32'h0);
        chk(wr_b, 2'h0);
        rc(8'h0C, 32'h3);
        wr(8'h04, 32'h1);
        repeat (6) @(posedge aclk);
        rc(8'h0C, 32'h2);
        wr(8'h00, 32'h03);
        repeat (6) @(posedge aclk);
        rc(8'h0C, 32'h0);
        results();
    end
endmodule // hsd_top_test

`default_nettype wire
